// *** pkg/eeprom_pkg.sv ***
// constants, state codes and carrier types of the serial eeprom write control
package eeprom_pkg;

  // ==========================================================================
  // array shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ==========================================================================
  // command framing
  localparam logic [3:0] START_PAT     = 4'ha;
  localparam logic [3:0] OP_READ       = 4'h8;
  localparam logic [3:0] OP_WRITE      = 4'h4;
  localparam logic [3:0] OP_ENABLE     = 4'h3;
  localparam logic [3:0] OP_DISABLE    = 4'h0;
  localparam logic [3:0] OP_FILL       = 4'h1;
  localparam logic [4:0] HDR_LAST_BIT  = 5'h0b;
  localparam logic [4:0] DATA_LAST_BIT = 5'h1b;
  localparam logic [4:0] BIT_CNT_MAX   = 5'h1f;
  localparam logic [3:0] RD_IDX_LAST   = 4'hf;

  // ==========================================================================
  // reset values and stored levels
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic        READY_LEVEL = 1'b1;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int T_WR_MS         = 5;
  localparam int WR_CYCLES       = T_WR_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OUT_DELAY_NS    = 300;
  localparam int OUT_DELAY_CYC   = OUT_DELAY_NS / CLK_PERIOD_NS;
  localparam int STATUS_DELAY_NS = 500;
  localparam int STATUS_CYC      = STATUS_DELAY_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CLEAR = 3'b010,
    ST_PROG  = 3'b100
  } wr_state_t;

  typedef struct packed {
    logic              all;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } write_req_t;

  typedef struct packed {
    logic sel_n;
    logic reset_pin;
    logic rd_live;
    logic rd_bit;
    logic req_tog;
    logic one_tog;
  } link_bits_t;

endpackage

// *** hdl/level_sync.sv ***
// two flip-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// *** hdl/word_store.sv ***
// flip-flop word array with one write port and an asynchronous read port
`timescale 1ns/1ps
module word_store #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  // clock
  input  wire logic              clk_i,
  // write port
  input  wire logic              we_i,
  input  wire logic              all_i,
  input  wire logic [ADDR_W-1:0] waddr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // read port
  input  wire logic [ADDR_W-1:0] raddr_i,
  output logic      [DATA_W-1:0] rdata_o
);

  // no reset: contents model nonvolatile storage
  logic [DATA_W-1:0] mem [1<<ADDR_W];

  assign rdata_o = mem[raddr_i];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
        if (all_i || waddr_i == ADDR_W'(i)) begin
          mem[i] <= wdata_i;
        end
      end
    end
  end

endmodule

// *** hdl/eeprom_ctrl.sv ***
// serial eeprom command decode, read output and self-timed write cycle
//
// Functional notes
// - read data appears on serial out after the falling edge of clock sixteen.
// - a complete write first clears the word, then programs it.
// - busy pin goes low after the thirty-second clock, low until programming ends.
// - busy pin returns high after programming and stays high until next write.
// - busy pin level ignores select; it follows only the write cycle.
// - select low during a write shows status on serial out; select high floats it.
// - after a write serial out shows one; first one on serial in floats it.
// - reset during write shifting discards the command, output stays floating.
// - reset during clear or program aborts it and reports ready.
// - reset pin affects only write and fill-all, never read, enable, disable.
// - write-enable latch comes up cleared at power-up.
// - writes are ignored while the write-enable latch is cleared.
// - latch stays set until a disable command or power loss.
// - latch and enable/disable commands never affect reads.
// - command is start pattern, opcode, eight address bits, then sixteen data bits.
// - header 10101000 is read, 10100100 is write, each with an address.
// - serial input is sampled on each rising shift clock edge.
`timescale 1ns/1ps
module eeprom_ctrl
  import eeprom_pkg::*;
#(
  parameter int WR_CYCLES = eeprom_pkg::WR_CYCLES
) (
  // system clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // serial link
  input  wire logic shift_clock_pin_i,
  input  wire logic select_n_pin_i,
  input  wire logic serial_in_pin_i,
  output logic      serial_out_o,
  output logic      serial_out_oe_n_o,
  // write control pins
  input  wire logic reset_pin_i,
  output logic      ready_busy_pin_o
);

  import eeprom_pkg::*;

  localparam int CLR_CYC  = (WR_CYCLES / 2 < 1) ? 1 : WR_CYCLES / 2;
  localparam int PROG_CYC = (WR_CYCLES - CLR_CYC < 1) ? 1 : WR_CYCLES - CLR_CYC;
  localparam int TW       = $clog2(WR_CYCLES + 1);
  localparam logic [TW-1:0] CLR_LOAD  = TW'(CLR_CYC - 1);
  localparam logic [TW-1:0] PROG_LOAD = TW'(PROG_CYC - 1);

  // ==========================================================================
  // link domain: command shifting
  logic              started;
  logic [3:0]        hunt;
  logic [4:0]        bit_cnt;
  logic [22:0]       sr;
  logic [3:0]        op;
  logic [ADDR_W-1:0] cmd_addr;
  logic              rd_en;
  logic [3:0]        rd_idx;
  logic              rd_bit;
  logic              rd_live;
  logic              abort_seen;
  logic              one_seen;
  logic              wel;
  logic              req_tog;
  logic              one_tog;
  logic              rst_sk;
  write_req_t        req;
  logic [DATA_W-1:0] rd_word;

  // select high clears the frame state; only the latch, the toggles and the write request survive it
  wire        link_rst_n = reset_n_i & ~select_n_pin_i;
  wire [3:0]  next_hunt  = {hunt[2:0], serial_in_pin_i};
  wire [23:0] next_sr    = {sr, serial_in_pin_i};
  wire        hdr_done   = started && (bit_cnt == HDR_LAST_BIT);
  wire        data_done  = started && (bit_cnt == DATA_LAST_BIT);
  wire [3:0]  hdr_op     = next_sr[11:8];
  wire        is_wr      = (op == OP_WRITE) || (op == OP_FILL);
  wire        wr_accept  = data_done && is_wr && wel && !abort_seen && !rst_sk;

  level_sync #(.W(1)) u_reset_sk (
    .clk_i   (shift_clock_pin_i),
    .rst_n_i (link_rst_n),
    .d_i     (reset_pin_i),
    .q_o     (rst_sk)
  );

  always_ff @(posedge shift_clock_pin_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      started    <= 1'b0;
      hunt       <= 4'h0;
      bit_cnt    <= 5'h00;
      sr         <= 23'h000000;
      op         <= OP_DISABLE;
      cmd_addr   <= 8'h00;
      rd_en      <= 1'b0;
      rd_idx     <= 4'h0;
      abort_seen <= 1'b0;
      one_seen   <= 1'b0;
    end else begin
      hunt    <= next_hunt;
      sr      <= next_sr[22:0];
      started <= started | (next_hunt == START_PAT);
      if (started && bit_cnt != BIT_CNT_MAX) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      if (hdr_done) begin
        op       <= hdr_op;
        cmd_addr <= next_sr[7:0];
      end
      // read ignores reset pin and write-enable latch
      if (hdr_done && hdr_op == OP_READ) begin
        rd_en <= 1'b1;
      end
      if (rd_en && rd_idx != RD_IDX_LAST) begin
        rd_idx <= rd_idx + 4'h1;
      end
      if (rst_sk) begin
        abort_seen <= 1'b1;
      end
      if (serial_in_pin_i) begin
        one_seen <= 1'b1;
      end
    end
  end

  // read bits change on the falling edge, msb first
  always_ff @(negedge shift_clock_pin_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_bit  <= 1'b0;
      rd_live <= 1'b0;
    end else begin
      rd_live <= rd_en;
      if (rd_en) begin
        rd_bit <= rd_word[~rd_idx];
      end
    end
  end

  // state that outlives a frame
  always_ff @(posedge shift_clock_pin_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wel     <= 1'b0;
      req_tog <= 1'b0;
      one_tog <= 1'b0;
      req     <= '0;
    end else begin
      if (select_n_pin_i == 1'b0 && hdr_done && hdr_op == OP_ENABLE) begin
        wel <= 1'b1;
      end else if (select_n_pin_i == 1'b0 && hdr_done && hdr_op == OP_DISABLE) begin
        wel <= 1'b0;
      end
      if (select_n_pin_i == 1'b0 && wr_accept) begin
        req.all  <= (op == OP_FILL);
        req.addr <= cmd_addr;
        req.data <= next_sr[15:0];
        req_tog  <= ~req_tog;
      end
      if (select_n_pin_i == 1'b0 && serial_in_pin_i && !one_seen && !started) begin
        one_tog <= ~one_tog;
      end
    end
  end

  // ==========================================================================
  // system domain: crossing
  link_bits_t raw;
  link_bits_t syn;
  logic       req_prev;
  logic       one_prev;

  assign raw.sel_n     = select_n_pin_i;
  assign raw.reset_pin = reset_pin_i;
  assign raw.rd_live   = rd_live;
  assign raw.rd_bit    = rd_bit;
  assign raw.req_tog   = req_tog;
  assign raw.one_tog   = one_tog;

  level_sync #(.W($bits(link_bits_t))) u_link_sync (
    .clk_i   (mclk_i),
    .rst_n_i (reset_n_i),
    .d_i     (raw),
    .q_o     (syn)
  );

  wire req_evt = syn.req_tog ^ req_prev;
  wire one_evt = syn.one_tog ^ one_prev;
  wire sel_low = ~syn.sel_n;

  // ==========================================================================
  // system domain: self-timed clear and program
  wr_state_t     st;
  wr_state_t     next_st;
  logic [TW-1:0] timer;
  logic          status_show;
  write_req_t    cur;

  // req is stable: it only moves on the next accepted command, refused while busy
  wire wr_start  = req_evt && (st == ST_IDLE) && !syn.reset_pin;
  wire aborting  = (st != ST_IDLE) && syn.reset_pin;
  wire prog_end  = (st == ST_PROG) && (timer == '0) && !aborting;
  wire store_we  = wr_start || prog_end;
  wire store_all = wr_start ? req.all : cur.all;
  wire [ADDR_W-1:0] store_addr = wr_start ? req.addr : cur.addr;
  wire [DATA_W-1:0] store_data = wr_start ? ERASED_WORD : cur.data;

  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE:  if (wr_start) next_st = ST_CLEAR;
      ST_CLEAR: begin
        if (aborting) next_st = ST_IDLE;
        else if (timer == '0) next_st = ST_PROG;
      end
      ST_PROG:  if (aborting || timer == '0) next_st = ST_IDLE;
      default:  next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st       <= ST_IDLE;
      timer    <= '0;
      cur      <= '0;
      req_prev <= 1'b0;
      one_prev <= 1'b0;
    end else begin
      st       <= next_st;
      req_prev <= syn.req_tog;
      one_prev <= syn.one_tog;
      if (wr_start) begin
        cur   <= req;
        timer <= CLR_LOAD;
      end else if (st == ST_CLEAR && timer == '0) begin
        timer <= PROG_LOAD;
      end else if (timer != '0) begin
        timer <= timer - 1'b1;
      end
    end
  end

  word_store #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_store (
    .clk_i   (mclk_i),
    .we_i    (store_we),
    .all_i   (store_all),
    .waddr_i (store_addr),
    .wdata_i (store_data),
    .raddr_i (cmd_addr),
    .rdata_o (rd_word)
  );

  // ==========================================================================
  // system domain: pins
  wire next_ready = (next_st == ST_IDLE);
  // set wins over the clear from the first one on serial in
  wire next_show  = wr_start | (status_show & ~(one_evt && st == ST_IDLE));
  wire next_oe_n  = ~(sel_low & (syn.rd_live | status_show));
  wire next_out   = syn.rd_live ? syn.rd_bit : ready_busy_pin_o;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_busy_pin_o  <= READY_LEVEL;
      status_show       <= 1'b0;
      serial_out_o      <= 1'b0;
      serial_out_oe_n_o <= 1'b1;
    end else begin
      ready_busy_pin_o  <= next_ready;
      status_show       <= next_show;
      serial_out_o      <= next_out;
      serial_out_oe_n_o <= next_oe_n;
    end
  end

  // ==========================================================================
  // checks: link domain
  property p_read_start;
    @(posedge shift_clock_pin_i) disable iff (!link_rst_n)
      (hdr_done && hdr_op == OP_READ) |=> rd_en && rd_idx == 4'h0;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read not started after header");

  property p_write_needs_enable;
    @(posedge shift_clock_pin_i) disable iff (!link_rst_n)
      (data_done && is_wr && !wel) |=> $stable(req_tog);
  endproperty
  a_write_needs_enable: assert property (p_write_needs_enable) else $error("write passed with latch clear");

  property p_discard_on_reset;
    @(posedge shift_clock_pin_i) disable iff (!link_rst_n)
      (data_done && (abort_seen || rst_sk)) |=> $stable(req_tog);
  endproperty
  a_discard_on_reset: assert property (p_discard_on_reset) else $error("write kept despite reset");

  property p_disable_clears;
    @(posedge shift_clock_pin_i) disable iff (!link_rst_n)
      (hdr_done && hdr_op == OP_DISABLE) |=> !wel;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("disable left latch set");

  property p_hunt_before_start;
    @(posedge shift_clock_pin_i) disable iff (!link_rst_n)
      (!started && next_hunt != START_PAT) |=> !started && bit_cnt == 5'h00;
  endproperty
  a_hunt_before_start: assert property (p_hunt_before_start) else $error("bits counted before start");

  // ==========================================================================
  // checks: system domain
  logic [TW:0] busy_len;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) busy_len <= '0;
    else if (st == ST_IDLE) busy_len <= '0;
    else busy_len <= busy_len + 1'b1;
  end

  property p_busy_on_start;
    @(posedge mclk_i) disable iff (!reset_n_i)
      wr_start |=> (st == ST_CLEAR) && !ready_busy_pin_o ##1 !ready_busy_pin_o;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("busy pin not low at write start");

  property p_clear_then_prog;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (st == ST_CLEAR && timer == '0 && !syn.reset_pin) |=> st == ST_PROG;
  endproperty
  a_clear_then_prog: assert property (p_clear_then_prog) else $error("clear not followed by program");

  property p_cycle_length;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (st != ST_IDLE) |-> busy_len < (TW+1)'(WR_CYCLES);
  endproperty
  a_cycle_length: assert property (p_cycle_length) else $error("write cycle overran");

  property p_pin_tracks_cycle;
    @(posedge mclk_i) disable iff (!reset_n_i)
      ready_busy_pin_o == (st == ST_IDLE);
  endproperty
  a_pin_tracks_cycle: assert property (p_pin_tracks_cycle) else $error("busy pin off the write state");

  property p_abort;
    @(posedge mclk_i) disable iff (!reset_n_i)
      aborting |=> (st == ST_IDLE) && ready_busy_pin_o;
  endproperty
  a_abort: assert property (p_abort) else $error("reset did not abort the cycle");

  property p_float_deselected;
    @(posedge mclk_i) disable iff (!reset_n_i)
      syn.sel_n |=> serial_out_oe_n_o;
  endproperty
  a_float_deselected: assert property (p_float_deselected) else $error("serial out driven while deselected");

  property p_poll_busy;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (sel_low && st != ST_IDLE && !syn.rd_live) |=> !serial_out_oe_n_o && !serial_out_o;
  endproperty
  a_poll_busy: assert property (p_poll_busy) else $error("poll did not show busy");

  property p_one_floats;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (one_evt && st == ST_IDLE && !req_evt && !syn.rd_live) |=> ##1 serial_out_oe_n_o;
  endproperty
  a_one_floats: assert property (p_one_floats) else $error("serial out kept after first one");

  c_write_done: cover property (@(posedge mclk_i) disable iff (!reset_n_i) prog_end);
  c_abort:      cover property (@(posedge mclk_i) disable iff (!reset_n_i) aborting);
  c_poll:       cover property (@(posedge mclk_i) disable iff (!reset_n_i) sel_low && st == ST_PROG);
  c_read:       cover property (@(posedge mclk_i) disable iff (!reset_n_i) syn.rd_live && sel_low);

endmodule

// *** bench/host_model.sv ***
// host side model: drives command frames on the serial link and polls status
`timescale 1ns/1ps
module host_model (
  // link outputs
  output logic      shift_clock_o,
  output logic      select_n_o,
  output logic      serial_in_o,
  // device data pin as split by the design
  input  wire logic serial_out_i,
  input  wire logic serial_out_oe_n_i
);
  logic last = 1'b0;
  logic line;

  // the pin has no pull, so a floating pin shows the inverse of its last driven level
  always @(serial_out_i or serial_out_oe_n_i) if (!serial_out_oe_n_i) last = serial_out_i;
  assign line = serial_out_oe_n_i ? ~last : serial_out_i;

  initial begin
    shift_clock_o = 1'b0;
    select_n_o    = 1'b1;
    serial_in_o   = 1'b0;
  end

  // ==========
  // frame: n bits msb first over m rising edges; the clock stands still outside frames
  // data launched on a falling edge is sampled two rising edges later, so slow answers still fit
  task automatic frame(input logic [39:0] bits, input int n, input int m, output logic [15:0] got);
    got = 16'h0000;
    select_n_o = 1'b0;
    #100;
    for (int i = 0; i < m; i++) begin
      serial_in_o = (i < n) ? bits[n-1-i] : 1'b0;
      #40 shift_clock_o = 1'b1;
      #20 got = {got[14:0], line};
      #20 shift_clock_o = 1'b0;
    end
    #40 select_n_o = 1'b1;
    serial_in_o = 1'b0;
    #200;
  endtask

  // ==========
  // poll: select low with no clocks, sample the data pin, deselect
  task automatic poll(output logic oe_n, output logic lvl);
    select_n_o = 1'b0;
    #400 oe_n = serial_out_oe_n_i;
    lvl = line;
    select_n_o = 1'b1;
    #200;
  endtask
endmodule

// *** bench/serial_eeprom_write_control_tb_top.sv ***
// self-checking bench for the serial eeprom write control
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module serial_eeprom_write_control_tb_top;
  import eeprom_pkg::*;
  localparam int WR_SIM = 40;
  logic        mclk_i;
  logic        reset_n_i;
  logic        reset_pin_i;
  logic        sk;
  logic        sel_n;
  logic        din;
  logic        dout;
  logic        dout_oe_n;
  logic        rdy;
  logic [15:0] got;
  logic        oe_n;
  logic        lvl;
  int          fail_count = 0;
  int          checked = 0;

  eeprom_ctrl #(.WR_CYCLES(WR_SIM)) eeprom_ctrl_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .shift_clock_pin_i(sk), .select_n_pin_i(sel_n),
    .serial_in_pin_i(din), .serial_out_o(dout), .serial_out_oe_n_o(dout_oe_n),
    .reset_pin_i(reset_pin_i), .ready_busy_pin_o(rdy));

  host_model host_model_inst (
    .shift_clock_o(sk), .select_n_o(sel_n), .serial_in_o(din),
    .serial_out_i(dout), .serial_out_oe_n_i(dout_oe_n));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // ==========
  // shared helpers
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    host_model_inst.frame({24'h000000, START_PAT, OP_READ, a}, 16, 33, got);
    `CHK("read data", exp, got)
    `CHK("data pin floats after read", 1'b1, dout_oe_n)
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_model_inst.frame({8'h00, START_PAT, OP_WRITE, a, d}, 32, 33, got);
  endtask

  task automatic cmd(input logic [3:0] op);
    host_model_inst.frame({24'h000000, START_PAT, op, 8'h00}, 16, 17, got);
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 200) begin
      @(posedge mclk_i);
      #2;
      k++;
    end
    `CHK("ready within limit", 1'b1, rdy)
  endtask

  task automatic set_reset_pin(input logic v);
    @(posedge mclk_i);
    #2 reset_pin_i = v;
  endtask

  // ==========
  // scenarios
  task automatic t_powerup;
    wr(8'h11, 16'h1234);
    `CHK("write refused at power-up", 1'b1, rdy)
    host_model_inst.poll(oe_n, lvl);
    `CHK("no status before any write", 1'b1, oe_n)
    $display("test powerup done");
  endtask

  task automatic t_write_read;
    cmd(OP_ENABLE);
    wr(8'h5a, 16'hc3a5);
    `CHK("busy after last data bit, deselected", 1'b0, rdy)
    host_model_inst.poll(oe_n, lvl);
    `CHK("busy pin ignores select", 1'b0, rdy)
    `CHK("poll drives pin", 1'b0, oe_n)
    `CHK("poll shows busy", 1'b0, lvl)
    wait_ready;
    `CHK("ready after programming", 1'b1, rdy)
    host_model_inst.poll(oe_n, lvl);
    `CHK("ready level on pin", 1'b1, lvl)
    rd(8'h5a, 16'hc3a5);
    host_model_inst.poll(oe_n, lvl);
    `CHK("first one floats status", 1'b1, oe_n)
    $display("test write_read done");
  endtask

  task automatic t_abort_busy;
    wr(8'h33, 16'h0f0f);
    set_reset_pin(1'b1);
    repeat (4) @(posedge mclk_i);
    #2;
    `CHK("abort shows ready", 1'b1, rdy)
    host_model_inst.poll(oe_n, lvl);
    `CHK("abort ready on data pin", 1'b1, lvl)
    set_reset_pin(1'b0);
    rd(8'h33, ERASED_WORD);
    $display("test abort_busy done");
  endtask

  task automatic t_abort_shift;
    fork
      wr(8'h5a, 16'h0000);
      begin
        repeat (25) @(posedge mclk_i);
        #2 reset_pin_i = 1'b1;
        repeat (10) @(posedge mclk_i);
        #2 reset_pin_i = 1'b0;
      end
    join
    `CHK("no write after mid-frame reset", 1'b1, rdy)
    `CHK("data pin floats", 1'b1, dout_oe_n)
    rd(8'h5a, 16'hc3a5);
    $display("test abort_shift done");
  endtask

  task automatic t_latch;
    wait_ready;
    set_reset_pin(1'b1);
    cmd(OP_DISABLE);
    rd(8'h5a, 16'hc3a5);
    set_reset_pin(1'b0);
    wr(8'h5a, 16'h1111);
    `CHK("write refused when disabled", 1'b1, rdy)
    rd(8'h5a, 16'hc3a5);
    set_reset_pin(1'b1);
    cmd(OP_ENABLE);
    set_reset_pin(1'b0);
    wr(8'h5a, 16'h2222);
    `CHK("enable under reset pin took effect", 1'b0, rdy)
    wait_ready;
    rd(8'h5a, 16'h2222);
    $display("test latch done");
  endtask

  task automatic t_start_hunt;
    host_model_inst.frame({24'h000000, START_PAT, OP_READ, 8'h5a}, 18, 35, got);
    `CHK("read after leading zeros", 16'h2222, got)
    $display("test start_hunt done");
  endtask

  // fill-all clears then programs every word
  task automatic t_fill;
    host_model_inst.frame({8'h00, START_PAT, OP_FILL, 8'h00, 16'h6b6b}, 32, 33, got);
    `CHK("busy after fill frame", 1'b0, rdy)
    wait_ready;
    rd(8'h5a, 16'h6b6b);
    rd(8'h9e, 16'h6b6b);
    $display("test fill done");
  endtask

  // ==========
  // verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    end_of_test;
  end

  initial begin
    reset_n_i   = 1'b0;
    reset_pin_i = 1'b0;
    repeat (12) @(posedge mclk_i);
    #2 reset_n_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #2;
    t_powerup;
    t_write_read;
    t_abort_busy;
    t_abort_shift;
    t_latch;
    t_start_hunt;
    t_fill;
    end_of_test;
  end
endmodule
